// File: hdl/supervisor_defines.svh
// Timing counts and encodings for the supply supervisor and watchdog
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH
`define CLK_HZ 25000000
// Reset hold times in ms
`define HOLD0_MS 50
`define HOLD1_MS 200
`define HOLD2_MS 400
`define HOLD3_MS 800
// Watchdog intervals in ms
`define WD0_MS 25
`define WD1_MS 200
`define WD2_MS 1400
// Each ms is exactly 25000 cycles at 25 MHz, so no time rounds
`define MS_TO_CYC(ms) ((ms) * (`CLK_HZ / 1000))
// Manual reset debounce time in us
`define DEBOUNCE_US 10
`define DEBOUNCE_CYC ((`DEBOUNCE_US * (`CLK_HZ / 1000000)))
// Watchdog select encodings
`define WD_SEL_25MS 2'h0
`define WD_SEL_200MS 2'h1
`define WD_SEL_1400MS 2'h2
`define WD_SEL_OFF 2'h3
`endif

// File: hdl/supervisor_pkg.sv
// Types shared by the supply supervisor
package supervisor_pkg;
  typedef logic [1:0] sel2_t;
  typedef struct packed {
    logic main_below_primary;
    logic main_below_battery;
    logic second_below_secondary;
  } comparators_t;
  typedef struct packed {
    logic sda_in;
    logic scl_in;
  } serial_in_t;
endpackage : supervisor_pkg

// File: hdl/supply_supervisor_watchdog.sv
// Reset generator, supply flags, battery switch select and watchdog
//
// Contract
// R1 - Four selectable reset hold periods: 0.05, 0.2, 0.4, 0.8 seconds.
// R2 - Watchdog intervals 25 ms, 200 ms, 1.4 s, or watchdog off.
// R3 - Host restarts watchdog in time, else watchdog alarm asserts.
// R4 - Chosen watchdog interval is kept nonvolatile across power cycles.
// R5 - At power-up system reset holds for the selected hold period.
// R6 - Reset while supply below primary threshold, then hold period after recovery.
// R7 - Second-monitor fail low while input below secondary threshold, no stretching.
// R8 - Early low-supply output low while main supply below primary threshold.
// R9 - Manual reset input is debounced before use.
// R10 - Battery selected only when main below low threshold and below battery.
// R11 - Manual reset holds reset, then hold period after release.
// R12 - Data falling edge with clock activity, then stop, restarts watchdog. The code needs no clock activity: any SDA or SCL fall arms.
// R13 - Watchdog alarm is active low, asserted on timer expiry.
// R14 - Inputs synchronised; all durations counted on the internal clock.
// R15 - Watchdog-off stops the counter and keeps the alarm deasserted.
`timescale 1ns/10ps
`include "supervisor_defines.svh"
module supply_supervisor_watchdog #(
  parameter int HOLD0_CYC = `MS_TO_CYC(`HOLD0_MS),
  parameter int HOLD1_CYC = `MS_TO_CYC(`HOLD1_MS),
  parameter int HOLD2_CYC = `MS_TO_CYC(`HOLD2_MS),
  parameter int HOLD3_CYC = `MS_TO_CYC(`HOLD3_MS),
  parameter int WD0_CYC = `MS_TO_CYC(`WD0_MS),
  parameter int WD1_CYC = `MS_TO_CYC(`WD1_MS),
  parameter int WD2_CYC = `MS_TO_CYC(`WD2_MS),
  parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire supervisor_pkg::comparators_t comparators,
  input wire logic manual_reset_n,
  input wire supervisor_pkg::serial_in_t serial_in,
  input wire supervisor_pkg::sel2_t hold_select,
  input wire supervisor_pkg::sel2_t watchdog_select_in,
  input wire logic watchdog_select_write,
  input wire supervisor_pkg::sel2_t watchdog_select_stored,
  output logic watchdog_select_store_en,
  output supervisor_pkg::sel2_t watchdog_select_store_data,
  output logic system_reset,
  output logic early_low_supply_n,
  output logic early_low_supply_oe,
  output logic second_monitor_fail_n,
  output logic second_monitor_fail_oe,
  output logic watchdog_alarm_n,
  output logic watchdog_alarm_oe,
  output logic battery_select
);
  import supervisor_pkg::*;

  // ==========================================================
  // Input synchronisers
  localparam int SYNC_W = 6;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] raw_in;
  assign raw_in = {comparators.main_below_primary, comparators.main_below_battery,
                   comparators.second_below_secondary, manual_reset_n,
                   serial_in.sda_in, serial_in.scl_in};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      // Comparators idle at "below" and pins at high so power-up looks like a fault
      sync_a <= 6'h3F;
      sync_b <= 6'h3F;
    end else begin
      sync_a <= raw_in; // [R14]
      sync_b <= sync_a;
    end
  end

  logic main_low;
  logic main_below_batt;
  logic second_low;
  logic manual_pin_n;
  logic sda;
  logic scl;
  assign {main_low, main_below_batt, second_low, manual_pin_n, sda, scl} = sync_b;

  // ==========================================================
  // Supply flags and battery switch
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      early_low_supply_n <= 1'b0;
      second_monitor_fail_n <= 1'b0;
      battery_select <= 1'b0;
    end else begin
      early_low_supply_n <= !main_low; // [R8]
      second_monitor_fail_n <= !second_low; // [R7]
      battery_select <= main_low && main_below_batt; // [R10]
    end
  end
  // Open drain: drive only the low level
  assign early_low_supply_oe = !early_low_supply_n; // [R8]
  assign second_monitor_fail_oe = !second_monitor_fail_n;

  // ==========================================================
  // Manual reset debounce
  logic [23:0] deb_cnt;
  logic manual_active;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      deb_cnt <= 24'h000000;
      manual_active <= 1'b0;
    end else if ((!manual_pin_n) == manual_active) begin
      deb_cnt <= 24'h000000;
    end else if (deb_cnt >= 24'(DEBOUNCE_CYC - 1)) begin
      // Level must stay stable for the whole debounce time to be accepted
      manual_active <= !manual_pin_n; // [R9]
      deb_cnt <= 24'h000000;
    end else begin
      deb_cnt <= deb_cnt + 24'h000001;
    end
  end

  // ==========================================================
  // System reset hold timer
  logic [31:0] hold_len;
  always_comb begin
    unique case (hold_select) // [R1]
      2'h0: hold_len = 32'(HOLD0_CYC);
      2'h1: hold_len = 32'(HOLD1_CYC);
      2'h2: hold_len = 32'(HOLD2_CYC);
      default: hold_len = 32'(HOLD3_CYC);
    endcase
  end

  logic [31:0] hold_cnt;
  logic reset_cause;
  assign reset_cause = main_low || manual_active;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt <= 32'h00000000;
      system_reset <= 1'b1; // [R5]
    end else if (reset_cause) begin
      hold_cnt <= 32'h00000000; // [R6] [R11]
      system_reset <= 1'b1;
    end else if (system_reset) begin
      if (hold_cnt >= hold_len - 32'h00000001) begin
        system_reset <= 1'b0; // [R5] [R6] [R11]
      end else begin
        hold_cnt <= hold_cnt + 32'h00000001;
      end
    end
  end

  // ==========================================================
  // Watchdog interval selection, held in external nonvolatile storage
  sel2_t wd_sel;
  logic loaded;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_sel <= `WD_SEL_OFF;
      loaded <= 1'b0;
      watchdog_select_store_en <= 1'b0;
      watchdog_select_store_data <= `WD_SEL_OFF;
    end else begin
      watchdog_select_store_en <= 1'b0;
      if (!loaded) begin
        // Restore the stored choice after the reset release
        wd_sel <= watchdog_select_stored; // [R4]
        loaded <= 1'b1;
      end else if (watchdog_select_write && watchdog_select_in != wd_sel) begin
        wd_sel <= watchdog_select_in;
        watchdog_select_store_en <= 1'b1; // [R4]
        watchdog_select_store_data <= watchdog_select_in;
      end
    end
  end

  logic [31:0] wd_len;
  always_comb begin
    unique case (wd_sel) // [R2]
      `WD_SEL_25MS: wd_len = 32'(WD0_CYC);
      `WD_SEL_200MS: wd_len = 32'(WD1_CYC);
      default: wd_len = 32'(WD2_CYC);
    endcase
  end

  // ==========================================================
  // Restart detection: any SDA or SCL falling edge arms, then a stop restarts
  logic sda_d;
  logic scl_d;
  logic armed;
  logic restart;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_d <= 1'b1;
      scl_d <= 1'b1;
      armed <= 1'b0;
    end else begin
      sda_d <= sda;
      scl_d <= scl;
      if (restart) begin
        armed <= 1'b0;
      end else if ((sda_d && !sda) || (scl_d && !scl)) begin
        // Any falling data or clock edge counts as bus activity
        armed <= armed || (sda_d && !sda) || !scl; // [R12]
      end
    end
  end
  // Stop condition: SDA rises while SCL is high
  assign restart = armed && scl && scl_d && !sda_d && sda; // [R12]

  // ==========================================================
  // Watchdog counter and alarm
  logic [31:0] wd_cnt;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt <= 32'h00000000;
      watchdog_alarm_n <= 1'b1;
    end else if (wd_sel == `WD_SEL_OFF || system_reset) begin
      wd_cnt <= 32'h00000000; // [R15]
      watchdog_alarm_n <= 1'b1; // [R15]
    end else if (restart) begin
      wd_cnt <= 32'h00000000; // [R3]
      watchdog_alarm_n <= 1'b1;
    end else if (wd_cnt >= wd_len - 32'h00000001) begin
      // Alarm stays until a restart, watchdog-off or system reset so a slow host still sees it
      watchdog_alarm_n <= 1'b0; // [R3] [R13]
    end else begin
      wd_cnt <= wd_cnt + 32'h00000001;
    end
  end
  assign watchdog_alarm_oe = !watchdog_alarm_n; // [R13]
endmodule : supply_supervisor_watchdog

// File: test/supervisor_monitor.sv
// Checker for reset, flag, battery and watchdog behaviour at the supervisor ports
`timescale 1ns/10ps
module supervisor_monitor #(
  parameter int HOLD0_CYC = 50
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire supervisor_pkg::comparators_t comparators,
  input wire logic manual_reset_n,
  input wire logic system_reset,
  input wire logic early_low_supply_n,
  input wire logic early_low_supply_oe,
  input wire logic second_monitor_fail_n,
  input wire logic second_monitor_fail_oe,
  input wire logic watchdog_alarm_n,
  input wire logic watchdog_alarm_oe,
  input wire logic battery_select,
  input wire logic watchdog_select_store_en
);
  import supervisor_pkg::*;
  logic [11:0] good_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Helpers
  // Saturates so a long good stretch cannot wrap back below the hold
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) good_cnt <= '0;
    else if (comparators.main_below_primary || !manual_reset_n) good_cnt <= '0;
    else if (good_cnt != 12'hFFF) good_cnt <= good_cnt + 12'h1;
  end
  sequence main_low_s; comparators.main_below_primary [*5]; endsequence
  sequence main_good_s; !comparators.main_below_primary [*5]; endsequence
  // ==========================================
  // Assertions
  low_reset_a: assert property (main_low_s |-> system_reset && !early_low_supply_n)
    else $error("reset or low flag missing");
  low_release_a: assert property (main_good_s |-> early_low_supply_n && !battery_select)
    else $error("low flag or battery stuck");
  second_low_a: assert property (comparators.second_below_secondary [*5] |-> !second_monitor_fail_n)
    else $error("second fail missing");
  second_high_a: assert property (!comparators.second_below_secondary [*5] |-> second_monitor_fail_n)
    else $error("second fail stretched");
  battery_pick_a: assert property ((comparators.main_below_primary && comparators.main_below_battery) [*5] |-> battery_select)
    else $error("battery not selected");
  open_drain_a: assert property ((early_low_supply_oe != early_low_supply_n) && (second_monitor_fail_oe != second_monitor_fail_n) && (watchdog_alarm_oe != watchdog_alarm_n))
    else $error("enable does not match level");
  store_pulse_a: assert property (watchdog_select_store_en |=> !watchdog_select_store_en)
    else $error("store pulse too long");
  alarm_quiet_a: assert property (system_reset [*2] |-> watchdog_alarm_n)
    else $error("alarm during reset");
  hold_time_a: assert property ($fell(system_reset) |-> good_cnt >= HOLD0_CYC)
    else $error("reset released too early");
endmodule : supervisor_monitor
bind supply_supervisor_watchdog supervisor_monitor #(.HOLD0_CYC(HOLD0_CYC)) u_monitor (
  .sys_clk(sys_clk), .arst_n(arst_n), .comparators(comparators), .manual_reset_n(manual_reset_n),
  .system_reset(system_reset), .early_low_supply_n(early_low_supply_n),
  .early_low_supply_oe(early_low_supply_oe), .second_monitor_fail_n(second_monitor_fail_n),
  .second_monitor_fail_oe(second_monitor_fail_oe), .watchdog_alarm_n(watchdog_alarm_n),
  .watchdog_alarm_oe(watchdog_alarm_oe), .battery_select(battery_select),
  .watchdog_select_store_en(watchdog_select_store_en));

// File: test/host_restart_model.sv
// Host model that restarts the watchdog over the serial lines
`timescale 1ns/10ps
module host_restart_model (
  input wire logic sys_clk,
  input wire logic kick,
  output supervisor_pkg::serial_in_t serial
);
  import supervisor_pkg::*;
  // Lines idle high through the bus pull-ups
  initial serial = 2'h3;
  // Clock low, data falls, clock high, data rises: a stop after the fall
  always @(posedge kick) begin
    @(negedge sys_clk);
    serial.scl_in = 1'h0;
    repeat (4) @(negedge sys_clk);
    serial.sda_in = 1'h0;
    repeat (4) @(negedge sys_clk);
    serial.scl_in = 1'h1;
    repeat (4) @(negedge sys_clk);
    serial.sda_in = 1'h1;
  end
endmodule : host_restart_model

// File: test/supply_supervisor_watchdog_tb.sv
// Self-checking testbench for the supply supervisor and watchdog
`timescale 1ns/10ps
module supply_supervisor_watchdog_tb;
  import supervisor_pkg::*;
  // Short cycle counts keep every hold and interval inside the run budget
  localparam int T_HOLD0 = 50;
  localparam int T_HOLD1 = 100;
  localparam int T_HOLD2 = 150;
  localparam int T_HOLD3 = 200;
  localparam int T_WD0 = 40;
  localparam int T_WD1 = 80;
  localparam int T_WD2 = 120;
  localparam int T_DEB = 4;
  logic sys_clk = 0, arst_n = 0, manual_n = 1, wr = 0, kick = 0, en, rst, low_n, fail_n;
  logic al_n, bat, low_oe, fail_oe, al_oe;
  comparators_t cmp = '0;
  sel2_t hsel = 2'h0, wsel = 2'h0, stored = 2'h3, sdat;
  serial_in_t ser;
  int num_errors = 0, comparisons = 0, cyc = 0;
  host_restart_model host (.sys_clk(sys_clk), .kick(kick), .serial(ser));
  supply_supervisor_watchdog #(.HOLD0_CYC(T_HOLD0), .HOLD1_CYC(T_HOLD1), .HOLD2_CYC(T_HOLD2),
    .HOLD3_CYC(T_HOLD3), .WD0_CYC(T_WD0), .WD1_CYC(T_WD1), .WD2_CYC(T_WD2),
    .DEBOUNCE_CYC(T_DEB)) DUT (
    .sys_clk(sys_clk), .arst_n(arst_n), .comparators(cmp), .manual_reset_n(manual_n),
    .serial_in(ser), .hold_select(hsel), .watchdog_select_in(wsel),
    .watchdog_select_write(wr), .watchdog_select_stored(stored),
    .watchdog_select_store_en(en), .watchdog_select_store_data(sdat), .system_reset(rst),
    .early_low_supply_n(low_n), .early_low_supply_oe(low_oe), .second_monitor_fail_n(fail_n),
    .second_monitor_fail_oe(fail_oe), .watchdog_alarm_n(al_n), .watchdog_alarm_oe(al_oe),
    .battery_select(bat));
  initial forever #20 sys_clk = ~sys_clk;
  // Stands in for the nonvolatile cell holding the watchdog choice
  always @(posedge sys_clk) if (en) stored <= sdat;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk(logic [1:0] got, logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %b want %b", $time, got, exp);
    end
  endtask : chk
  task automatic w(int n); repeat (n) @(negedge sys_clk); endtask : w
  task automatic wr_sel(sel2_t s); wsel = s; wr = 1; w(1); wr = 0; endtask : wr_sel
  task automatic restart(); kick = 1; w(25); kick = 0; endtask : restart
  task automatic t_hold();
    for (int s = 0; s < 4; s++) begin
      hsel = s[1:0];
      cmp.main_below_primary = 1;
      w(10);
      chk(rst, 1);
      chk(low_n, 0);
      chk(low_oe, 1);
      cmp.main_below_primary = 0;
      w(45 + 50 * s);
      chk(rst, 1);
      w(15);
      chk(rst, 0);
    end
  endtask : t_hold
  task automatic t_flags();
    hsel = 2'h0;
    cmp.second_below_secondary = 1;
    w(5);
    chk(fail_n, 0);
    chk(fail_oe, 1);
    cmp.second_below_secondary = 0;
    w(5);
    chk(fail_n, 1);
    chk(fail_oe, 0);
    cmp.main_below_battery = 1;
    w(5);
    chk(bat, 0);
    cmp.main_below_primary = 1;
    w(5);
    chk(bat, 1);
    cmp = '0;
    w(60);
  endtask : t_flags
  task automatic t_manual();
    manual_n = 0;
    w(2);
    manual_n = 1;
    w(10);
    chk(rst, 0);
    manual_n = 0;
    w(112);
    chk(rst, 1);
    manual_n = 1;
    w(45);
    chk(rst, 1);
    w(25);
    chk(rst, 0);
  endtask : t_manual
  task automatic t_wd();
    for (int s = 0; s < 3; s++) begin
      wr_sel(s[1:0]);
      restart();
      w(25 + 40 * s);
      chk(al_n, 1);
      chk(al_oe, 0);
      w(20);
      chk(al_n, 0);
      chk(al_oe, 1);
    end
    wr_sel(2'h3);
    w(155);
    chk(al_n, 1);
  endtask : t_wd
  task automatic t_nv();
    wr_sel(2'h1);
    w(3);
    chk(stored, 2'h1);
    arst_n = 0;
    w(10);
    arst_n = 1;
    w(120);
    chk(al_n, 1);
    w(30);
    chk(al_n, 0);
  endtask : t_nv
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    w(10);
    arst_n = 1;
    w(40);
    chk(rst, 1);
    w(40);
    chk(rst, 0);
    t_hold();
    t_flags();
    t_manual();
    t_wd();
    t_nv();
    wrap_up();
  end
endmodule : supply_supervisor_watchdog_tb
